// ==== common/ubrg_pkg.sv ====
// Package: register map, field positions and timing constants of the baud rate generator
package ubrg_pkg;

    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned DIV_W           = 8;
    localparam int unsigned PRE_LOW         = 64;
    localparam int unsigned PRE_HIGH        = 16;

    localparam logic [11:0] OFF_DIVISOR     = 12'h000;
    localparam logic [11:0] OFF_CONTROL     = 12'h004;
    localparam logic [11:0] OFF_STATUS      = 12'h008;

    localparam int unsigned HSEL_BIT        = 5;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  DIV_RESET       = 8'h00;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    typedef enum logic [1:0] {
        UBRG_LOW  = 2'h1,
        UBRG_HIGH = 2'h2
    } ubrg_speed_t;

    function automatic logic [8:0] ubrg_div_plus_one(input logic [7:0] d);
        return {1'b0, d} + 9'h001;
    endfunction

endpackage

// ==== design/ubrg_counter.sv ====
// Divisor counter: 8-bit free-running down counter reloaded from the divisor
module ubrg_counter
    import ubrg_pkg::*;
#(
    parameter int unsigned WIDTH = DIV_W
)
(
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             clk_en,
    // Control
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] divisor,
    // Outputs
    output logic                  period_done,
    output logic [WIDTH-1:0]      count
);
    // Elaboration-time refusal: the reload path is as wide as the divisor register
    if (WIDTH != DIV_W) begin : g_width_check
        $error("ubrg_counter: width must match divisor register");
    end

    logic [WIDTH-1:0] cnt_reg;

    // Zero divisor means every prescaler pulse ends a period
    assign period_done = clk_en && step && (cnt_reg == '0);
    assign count       = cnt_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
        end else if (clk_en && step) begin
            if (cnt_reg == '0) begin
                cnt_reg <= divisor;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

endmodule

// ==== design/ubrg_prescaler.sv ====
// Prescaler: divides the source clock by 16 or 64 into a one-cycle pulse
module ubrg_prescaler
    import ubrg_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic clk_en,
    // Control
    input  wire logic high_speed_select,
    // Pulse out
    output logic      pre_tick
);
    logic [5:0] pre_reg;
    logic [5:0] pre_limit;

    // Terminal count follows the speed select at once; a change mid-period
    // only lengthens or shortens that one period.
    assign pre_limit = high_speed_select ? 6'(PRE_HIGH - 1) : 6'(PRE_LOW - 1);
    assign pre_tick  = clk_en && (pre_reg >= pre_limit);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 6'h00;
        end else if (clk_en) begin
            if (pre_reg >= pre_limit) begin
                pre_reg <= 6'h00;
            end else begin
                pre_reg <= pre_reg + 6'h01;
            end
        end
    end

endmodule

// ==== design/ubrg_top.sv ====
// Baud rate generator top: AHB-Lite register slave, prescaler and divisor counter
module ubrg_top
    import ubrg_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Bit-rate timing
    output logic             tx_baud_tick,
    output logic             rx_baud_tick
);
    logic [7:0]  divisor_reg;
    logic [7:0]  control_reg;
    logic        wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] rdata_next;
    logic        pre_tick;
    logic        period_done;
    logic [7:0]  count;
    logic        tick_reg;
    logic [7:0]  lap_reg;
    logic        high_speed_select;
    logic        addr_ok;

    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign high_speed_select = control_reg[HSEL_BIT];
    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

    // Write data arrives one cycle after its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else if (clk_en) begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // Divisor has no defined power-on value; zero is used so simulation is clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divisor_reg <= DIV_RESET;
        end else if (clk_en && wr_pend_reg && wr_addr_reg == OFF_DIVISOR) begin
            divisor_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= CTRL_RESET;
        end else if (clk_en && wr_pend_reg && wr_addr_reg == OFF_CONTROL) begin
            control_reg <= CTRL_RESET | (8'(hwdata[HSEL_BIT]) << HSEL_BIT);
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (haddr)
            OFF_DIVISOR: rdata_next = {24'h000000, divisor_reg};
            OFF_CONTROL: rdata_next = {24'h000000, control_reg};
            OFF_STATUS:  rdata_next = {16'h0000, lap_reg, count};
            default:     rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && addr_ok && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    ubrg_prescaler u_ubrg_prescaler (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .clk_en            (clk_en),
        .high_speed_select (high_speed_select),
        .pre_tick          (pre_tick)
    );

    ubrg_counter #(.WIDTH(DIV_W)) u_ubrg_counter (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .clk_en      (clk_en),
        .step        (pre_tick),
        .divisor     (divisor_reg),
        .period_done (period_done),
        .count       (count)
    );

    // Registered tick, fanned out unchanged so both directions stay in step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_reg <= 1'b0;
        end else if (clk_en) begin
            tick_reg <= period_done;
        end
    end

    assign tx_baud_tick = tick_reg;
    assign rx_baud_tick = tick_reg;

    // Period counter lets software see the generator running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lap_reg <= 8'h00;
        end else if (clk_en && period_done) begin
            lap_reg <= lap_reg + 8'h01;
        end
    end

    // Helper: cycles since last tick
    logic [15:0] gap_reg;
    logic        seen_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_reg  <= 16'h0000;
            seen_reg <= 1'b0;
        end else if (clk_en) begin
            if (tick_reg) begin
                gap_reg  <= 16'h0001;
                seen_reg <= 1'b1;
            end else begin
                gap_reg <= gap_reg + 16'h0001;
            end
        end
    end

    // A register write inside a period makes that period's length unpredictable,
    // so such periods are not timed; the set wins over the clear at a reload
    logic        cfg_wr;
    logic        dirty_reg;
    assign cfg_wr = clk_en && wr_pend_reg
        && (wr_addr_reg == OFF_DIVISOR || wr_addr_reg == OFF_CONTROL);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dirty_reg <= 1'b1;
        end else if (cfg_wr) begin
            dirty_reg <= 1'b1;
        end else if (clk_en && period_done) begin
            dirty_reg <= 1'b0;
        end
    end

    logic [15:0] expect_gap;
    assign expect_gap = 16'(ubrg_div_plus_one(divisor_reg))
        * (high_speed_select ? 16'(PRE_HIGH) : 16'(PRE_LOW));

    // At the reload the gap counter holds one less than the period just ended
    property p_period;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && period_done && seen_reg && !dirty_reg)
            |-> (gap_reg == expect_gap - 16'h0001);
    endproperty
    a_period: assert property (p_period) else $error("tick period check");

    property p_low_gap;
        @(posedge hclk) disable iff (!hresetn)
        (!high_speed_select && !tick_reg) |-> (gap_reg <= 16'(PRE_LOW) * 16'h0100);
    endproperty
    a_low_gap: assert property (p_low_gap) else $error("low speed gap too long");

    property p_high_gap;
        @(posedge hclk) disable iff (!hresetn)
        // A speed change may cut the running prescale period short once
        (clk_en && high_speed_select && pre_tick && $stable(control_reg))
            |-> (u_ubrg_prescaler.pre_reg == 6'(PRE_HIGH - 1));
    endproperty
    a_high_gap: assert property (p_high_gap) else $error("high speed prescale wrong");

    property p_zero_div;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && pre_tick && divisor_reg == 8'h00 && count == 8'h00)
            |=> (tick_reg && count == 8'h00);
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("zero divisor no tick");

    property p_div_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_reg && wr_addr_reg == OFF_DIVISOR) |=> (divisor_reg == $past(hwdata[7:0]));
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor write lost");

    property p_hsel_map;
        @(posedge hclk) disable iff (!hresetn)
        (control_reg & ~(8'h01 << HSEL_BIT)) == 8'h00;
    endproperty
    a_hsel_map: assert property (p_hsel_map) else $error("control stray bits");

    property p_shared;
        @(posedge hclk) disable iff (!hresetn)
        tx_baud_tick == rx_baud_tick;
    endproperty
    a_shared: assert property (p_shared) else $error("tx and rx ticks differ");

    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && period_done) |=> (count == $past(divisor_reg)) && tick_reg;
    endproperty
    a_reload: assert property (p_reload) else $error("reload or tick missing");

    property p_exact;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && seen_reg && !dirty_reg && !tick_reg) |-> (gap_reg < expect_gap);
    endproperty
    a_exact: assert property (p_exact) else $error("tick period overrun");

    property p_tick_one;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && tick_reg) |=> !tick_reg;
    endproperty
    a_tick_one: assert property (p_tick_one) else $error("tick longer than one cycle");

    property p_lap;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && period_done) |=> (lap_reg == $past(lap_reg) + 8'h01);
    endproperty
    a_lap: assert property (p_lap) else $error("period counter missed a period");

    property p_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_reg && wr_addr_reg == OFF_CONTROL)
            |=> (high_speed_select == $past(hwdata[HSEL_BIT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("speed select write lost");

    property p_rd_div;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && !hwrite && haddr == OFF_DIVISOR)
            |=> (hrdata == {24'h000000, $past(divisor_reg)});
    endproperty
    a_rd_div: assert property (p_rd_div) else $error("divisor read back wrong");

    property p_rd_ctrl;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && !hwrite && haddr == OFF_CONTROL)
            |=> (hrdata == {24'h000000, $past(control_reg)});
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read back wrong");

    property p_rd_status;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && !hwrite && haddr == OFF_STATUS)
            |=> (hrdata == {16'h0000, $past(lap_reg), $past(count)});
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read back wrong");

    // Unmapped reads return zero so software probing the map sees no stale data
    property p_rd_unmapped;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && !hwrite && haddr != OFF_DIVISOR && haddr != OFF_CONTROL
            && haddr != OFF_STATUS) |=> (hrdata == 32'h0000_0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_wr_pend;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && addr_ok && hwrite) |=> wr_pend_reg;
    endproperty
    a_wr_pend: assert property (p_wr_pend) else $error("write address phase not taken");

    property p_no_pend;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !(addr_ok && hwrite)) |=> !wr_pend_reg;
    endproperty
    a_no_pend: assert property (p_no_pend) else $error("write taken without request");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        !clk_en |=> ($stable(divisor_reg) && $stable(control_reg) && $stable(count)
            && $stable(tick_reg) && $stable(hrdata) && $stable(lap_reg));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_bus_resp;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp;
    endproperty
    a_bus_resp: assert property (p_bus_resp) else $error("bus response not okay");

endmodule

// ==== dv/tb_top.sv ====
// Self-checking testbench of the baud rate generator: register access and tick period timing
module tb_top
    import ubrg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        clk_en;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tx_baud_tick;
    logic        rx_baud_tick;
    int unsigned failures;
    int unsigned compares;
    logic [31:0] d;

    ubrg_top u_ubrg_top (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .clk_en       (clk_en),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hwdata       (hwdata),
        .hready       (hreadyout),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .tx_baud_tick (tx_baud_tick),
        .rx_baud_tick (rx_baud_tick)
    );

    always #10 hclk = ~hclk;

    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single AHB-Lite transfer; entered just after a rising edge, waits on hready each phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr  <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize  <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Counts edges up to the next tick; both tick outputs must agree on every cycle
    task automatic tick(output int unsigned c);
        c = 0;
        do begin
            @(posedge hclk);
            c++;
            chk({31'h0, rx_baud_tick}, {31'h0, tx_baud_tick});
        end while (tx_baud_tick !== 1'b1);
    endtask

    // Programs divisor and speed, reads both back, times one whole period,
    // then checks the reloaded count and one period step in the status word
    task automatic period(input logic [7:0] n, input logic hs);
        int unsigned c;
        int unsigned exp;
        logic [31:0] r;
        logic [31:0] s;
        exp = (hs ? PRE_HIGH : PRE_LOW) * (int'(n) + 1);
        bus(1'b1, OFF_DIVISOR, {24'h0, n}, r);
        bus(1'b1, OFF_CONTROL, {26'h0, hs, 5'h00}, r);
        bus(1'b0, OFF_CONTROL, 32'h0, r);
        chk(r, {26'h0, hs, 5'h00});
        bus(1'b0, OFF_DIVISOR, 32'h0, r);
        chk(r, {24'h0, n});
        // First periods may still run on the old divisor, so they are skipped
        tick(c);
        tick(c);
        tick(c);
        chk(c, exp);
        @(posedge hclk);
        chk({31'h0, tx_baud_tick}, 32'h0);
        // The counter moves only at a prescale pulse, at least 16 cycles after reload
        bus(1'b0, OFF_STATUS, 32'h0, s);
        chk({24'h0, s[7:0]}, {24'h0, n});
        tick(c);
        bus(1'b0, OFF_STATUS, 32'h0, r);
        chk(r, {16'h0, s[15:8] + 8'h01, n});
    endtask

    // Clock enable low for a few cycles must shift the next tick by as many
    task automatic freeze(input int unsigned exp);
        int unsigned c;
        tick(c);
        clk_en <= 1'b0;
        repeat (5) @(posedge hclk);
        chk({31'h0, tx_baud_tick}, 32'h0);
        clk_en <= 1'b1;
        tick(c);
        chk(c, exp);
    endtask

    initial begin
        hclk     = 1'b0;
        hresetn  = 1'b0;
        clk_en   = 1'b1;
        hsel     = 1'b1;
        haddr    = 12'h000;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = HSIZE_WORD;
        hwdata   = 32'h0;
        failures = 0;
        compares = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OFF_DIVISOR, 32'h0, d);
        chk(d, {24'h0, DIV_RESET});
        bus(1'b0, OFF_CONTROL, 32'h0, d);
        chk(d, {24'h0, CTRL_RESET});
        bus(1'b1, OFF_DIVISOR, 32'hffff_ff5a, d);
        bus(1'b0, OFF_DIVISOR, 32'h0, d);
        chk(d, 32'h0000_005a);
        bus(1'b0, 12'h0fc, 32'h0, d);
        chk(d, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        period(8'h00, 1'b0);
        period(8'h00, 1'b1);
        period(8'h02, 1'b1);
        freeze(PRE_HIGH * 3);
        period(8'hff, 1'b0);
        wrap_up();
    end

    // Longest case is about three whole periods at divisor 255, low speed, a little over 49152 cycles
    initial begin
        repeat (90000) @(posedge hclk);
        failures++;
        wrap_up();
    end
endmodule
